// *** tmc_pkg.sv ***
// package: constants and types for the timer capture channel
package tmc_pkg;

  // capture trigger select encodings
  localparam logic [1:0] CAP_OFF       = 2'h0;
  localparam logic [1:0] CAP_A_RISE    = 2'h1;
  localparam logic [1:0] CAP_A_RISE_FALL = 2'h2;
  localparam logic [1:0] CAP_GATE      = 2'h3;

  // flip-flop initialise field encodings
  localparam logic [1:0] FF_INVERT     = 2'h0;
  localparam logic [1:0] FF_SET        = 2'h1;
  localparam logic [1:0] FF_CLEAR      = 2'h2;

  // clock source select: 0 = ext input a, 1..3 = prescaler taps
  localparam logic [1:0] CLK_EXT       = 2'h0;

  // prescaler and reset values
  localparam int          PRESC_W       = 8;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [7:0]  PRESC_RST     = 8'h00;

  // tap positions of the prescaler (divide by 2, 8, 32)
  localparam int TAP1 = 0;
  localparam int TAP2 = 2;
  localparam int TAP3 = 4;

  // configuration bundle from software
  typedef struct packed {
    logic        run;               // counter run, 0 stops and clears
    logic        prescalerRun;      // prescaler run
    logic [1:0]  clockSelect;       // counter clock source
    logic        clearOnMatchEnable;
    logic [1:0]  captureTriggerSelect;
    logic        toggleOnMatchA;
    logic        toggleOnMatchB;
    logic        toggleOnCaptureA;
    logic        toggleOnCaptureB;
    logic [15:0] compareValueA;
    logic [15:0] compareValueB;
  } tmc_cfg_type;

  // event pulses to software
  typedef struct packed {
    logic matchAIrq;
    logic matchBIrq;
    logic overflowIrq;
  } tmc_irq_type;

  // whole state of the channel
  typedef struct packed {
    logic [1:0]  syncA;
    logic [1:0]  syncB;
    logic [1:0]  syncGate;
    logic        prevA;
    logic        prevB;
    logic        prevGate;
    logic [PRESC_W-1:0] presc;
    logic [PRESC_W-1:0] prescPrev;
    logic [15:0] upCounter;
    logic [15:0] captureValueA;
    logic [15:0] captureValueB;
    logic        outputToggleFf;
    logic        pulseOutputPin;
    tmc_irq_type irq;
  } tmc_state_type;

endpackage

// *** tmc_timer.sv ***
// timer channel: interval, event count, pulse generation and capture
`timescale 1ns/1ps
// Operation
// - compare b sets interval, raises match-b
// - event mode counts ext input a rises
// - software command latches counter into capture a
// - pulse mode toggles on a and b matches
// - flip-flop preset sets pulse polarity
// - flip-flop drives output pin when enabled
// - free counter captured on ext a rise
// - both toggle enables form one pulse
// - capture a can toggle flip-flop directly
// - gate flip-flop edges capture a then b
// - ext a rise to a, fall to b
// - ext a rise to a, ext b rise to b
// - clear-on-match returns counter to zero at b
// - each comparator raises its own match pulse
// - init field sets, clears or inverts flip-flop
// - counter wrap raises overflow pulse
module tmc_timer
(
  input  wire logic            ref_clk,
  input  wire logic            resetn,
  input  wire tmc_pkg::tmc_cfg_type cfg,
  input  wire logic            softCaptureStrobe,
  input  wire logic            ffInitStrobe,
  input  wire logic [1:0]      ffInitField,
  input  wire logic            pinTimerFunction,
  input  wire logic            extInputA,
  input  wire logic            extInputB,
  input  wire logic            gateTimerFf,
  output logic [15:0]          upCounter,
  output logic [15:0]          captureValueA,
  output logic [15:0]          captureValueB,
  output logic                 outputToggleFf,
  output logic                 pulseOutputPin,
  output tmc_pkg::tmc_irq_type irq
);
  import tmc_pkg::*;

  tmc_state_type state_r;
  tmc_state_type state_nxt;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  logic aRise;
  logic aFall;
  logic bRise;
  logic gRise;
  logic gFall;
  logic tick;
  logic matchA;
  logic matchB;
  logic capA;
  logic capB;
  logic toggle;
  logic [PRESC_W-1:0] prescRise;

  // one combinational pass over the whole state
  always_comb
  begin
    state_nxt = state_r;
    // input synchronisers, stage two only read by edge logic
    state_nxt.syncA    = {state_r.syncA[0], extInputA};
    state_nxt.syncB    = {state_r.syncB[0], extInputB};
    state_nxt.syncGate = {state_r.syncGate[0], gateTimerFf};
    state_nxt.prevA    = state_r.syncA[1];
    state_nxt.prevB    = state_r.syncB[1];
    state_nxt.prevGate = state_r.syncGate[1];
    aRise = state_r.syncA[1] & ~state_r.prevA;
    aFall = ~state_r.syncA[1] & state_r.prevA;
    bRise = state_r.syncB[1] & ~state_r.prevB;
    gRise = state_r.syncGate[1] & ~state_r.prevGate;
    gFall = ~state_r.syncGate[1] & state_r.prevGate;

    // free-running prescaler while enabled
    state_nxt.prescPrev = state_r.presc;
    state_nxt.presc = cfg.prescalerRun ? PRESC_W'(state_r.presc + 1'b1) : PRESC_RST;
    prescRise = state_r.presc & ~state_r.prescPrev;

    // counter clock enable from selected source
    unique case (cfg.clockSelect)
      CLK_EXT: tick = aRise;
      2'h1:    tick = prescRise[TAP1];
      2'h2:    tick = prescRise[TAP2];
      2'h3:    tick = prescRise[TAP3];
    endcase
    tick = tick & cfg.run & cfg.prescalerRun;

    // comparators against the live count
    matchA = cfg.run && state_r.upCounter == cfg.compareValueA;
    matchB = cfg.run && state_r.upCounter == cfg.compareValueB;
    state_nxt.irq.matchAIrq   = tick & matchA;
    state_nxt.irq.matchBIrq   = tick & matchB;
    state_nxt.irq.overflowIrq = tick & (&state_r.upCounter);

    // counting, clear on b match, stop clears
    if (!cfg.run)
      state_nxt.upCounter = COUNT_RST;
    else if (tick && matchB && cfg.clearOnMatchEnable)
      state_nxt.upCounter = COUNT_RST;
    else if (tick)
      state_nxt.upCounter = state_r.upCounter + 16'h0001;

    // capture trigger selection
    capA = 1'b0;
    capB = 1'b0;
    if (cfg.prescalerRun)
    begin
      unique case (cfg.captureTriggerSelect)
        CAP_OFF:         ;
        CAP_A_RISE:      begin capA = aRise; capB = bRise; end
        CAP_A_RISE_FALL: begin capA = aRise; capB = aFall; end
        CAP_GATE:        begin capA = gRise; capB = gFall; end
      endcase
    end
    capA = capA | softCaptureStrobe;
    if (capA)
      state_nxt.captureValueA = state_r.upCounter;
    if (capB)
      state_nxt.captureValueB = state_r.upCounter;

    // output flip-flop toggling and software init
    toggle = (tick & matchA & cfg.toggleOnMatchA)
           ^ (tick & matchB & cfg.toggleOnMatchB)
           ^ (capA & cfg.toggleOnCaptureA)
           ^ (capB & cfg.toggleOnCaptureB);
    if (ffInitStrobe)
    begin
      unique case (ffInitField)
        FF_SET:   state_nxt.outputToggleFf = 1'b1;
        FF_CLEAR: state_nxt.outputToggleFf = 1'b0;
        FF_INVERT: state_nxt.outputToggleFf = ~state_r.outputToggleFf;
        default:  state_nxt.outputToggleFf = state_r.outputToggleFf;
      endcase
    end
    else if (toggle)
      state_nxt.outputToggleFf = ~state_r.outputToggleFf;
    state_nxt.pulseOutputPin = pinTimerFunction & state_nxt.outputToggleFf;
  end

  // state register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  // outputs straight from state
  assign upCounter      = state_r.upCounter;
  assign captureValueA  = state_r.captureValueA;
  assign captureValueB  = state_r.captureValueB;
  assign outputToggleFf = state_r.outputToggleFf;
  assign pulseOutputPin = state_r.pulseOutputPin;
  assign irq            = state_r.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // a running counter that steps in this cycle
  sequence s_countTick;
    cfg.run && tick;
  endsequence

  // capture a with no count step in the same cycle
  sequence s_captureHold;
    cfg.run && capA && !tick;
  endsequence

  a_capture_a_val: assert property (capA |=> captureValueA == $past(upCounter))
    else $error("capture a wrong");
  a_capture_keeps: assert property (s_captureHold |=> upCounter == $past(upCounter))
    else $error("capture moved the counter");
  a_irq_one_cycle: assert property (s_countTick ##0 matchB |=> ##1 !irq.matchBIrq)
    else $error("match b pulse too long");
  a_pin_parked: assert property (!pinTimerFunction |=> !pulseOutputPin)
    else $error("pin driven outside timer function");
  a_ff_invert_init: assert property (ffInitStrobe && ffInitField == FF_INVERT
      |=> outputToggleFf != $past(outputToggleFf))
    else $error("flip-flop not inverted");

  a_match_b_irq: assert property (tick && matchB |=> irq.matchBIrq)
    else $error("match b pulse missing");
  a_match_a_irq: assert property (tick && matchA |=> irq.matchAIrq)
    else $error("match a pulse missing");
  a_overflow_wrap: assert property (tick && upCounter == 16'hffff && cfg.run |=> irq.overflowIrq && upCounter == 16'h0000)
    else $error("overflow not flagged");
  a_event_count: assert property (cfg.run && cfg.prescalerRun && cfg.clockSelect == CLK_EXT && aRise
      && !(matchB && cfg.clearOnMatchEnable) |=> upCounter == $past(upCounter) + 16'h0001)
    else $error("event not counted");
  a_clear_on_b: assert property (tick && matchB && cfg.clearOnMatchEnable |=> upCounter == 16'h0000)
    else $error("counter not cleared at b");
  a_soft_capture: assert property (softCaptureStrobe |=> captureValueA == $past(upCounter))
    else $error("soft capture wrong");
  a_capture_b_val: assert property (capB |=> captureValueB == $past(upCounter))
    else $error("capture b wrong");
  a_ff_set_init: assert property (ffInitStrobe && ffInitField == FF_SET |=> outputToggleFf)
    else $error("flip-flop not set");
  a_ff_clear_init: assert property (ffInitStrobe && ffInitField == FF_CLEAR |=> !outputToggleFf)
    else $error("flip-flop not cleared");
  a_match_toggle: assert property (!ffInitStrobe && tick && matchA && cfg.toggleOnMatchA
      && !(matchB && cfg.toggleOnMatchB) && !capA && !capB |=> outputToggleFf != $past(outputToggleFf))
    else $error("no toggle on a match");
  a_pin_follows: assert property (pinTimerFunction |=> pulseOutputPin == outputToggleFf)
    else $error("pin does not follow flip-flop");
  a_gate_capture: assert property (cfg.prescalerRun && cfg.captureTriggerSelect == CAP_GATE && gRise
      |=> captureValueA == $past(upCounter))
    else $error("gate capture missing");

endmodule

// *** tmc_ext_src.sv ***
// model of the external trigger pins feeding the timer channel
`timescale 1ns/1ps
module tmc_ext_src (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [1:0] lineSel,
  input  wire logic [7:0] count,
  output logic            extInputA,
  output logic            extInputB,
  output logic            gateTimerFf,
  output logic            busy
);
  logic [2:0] lvl;
  assign extInputA   = lvl[0];
  assign extInputB   = lvl[1];
  assign gateTimerFf = lvl[2];
  // pulse one line count times, 4 cycles high and 4 low
  initial
  begin
    lvl = 3'h0;
    busy = 1'b0;
    forever
    begin
      do
        @(negedge ref_clk);
      while (!go);
      busy = 1'b1;
      repeat (count)
      begin
        lvl[lineSel] = 1'b1;
        repeat (4) @(negedge ref_clk);
        lvl[lineSel] = 1'b0;
        repeat (4) @(negedge ref_clk);
      end
      busy = 1'b0;
    end
  end
endmodule

// *** tb_tmc_timer.sv ***
// self-checking bench for the timer capture channel
`timescale 1ns/1ps
module tb_tmc_timer;
  import tmc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  tmc_cfg_type cfg = '0;
  logic        softCaptureStrobe = 1'b0;
  logic        ffInitStrobe = 1'b0;
  logic [1:0]  ffInitField = 2'h3;
  logic        pinTimerFunction = 1'b0;
  logic        go = 1'b0;
  logic [1:0]  lineSel = 2'h0;
  logic [7:0]  cnt = 8'h00;
  logic        extInputA, extInputB, gateTimerFf, busy, outputToggleFf, pulseOutputPin;
  logic [15:0] upCounter, captureValueA, captureValueB, n, cmpA, cmpB;
  tmc_irq_type irq, irqExp;
  tmc_irq_type irqQ[$];
  int          bad_count = 0;
  int          check_count = 0;
  int          seed = 11;
  int          hi = 0;
  always #10 ref_clk = ~ref_clk;
  tmc_timer tmc_timer_inst (.ref_clk(ref_clk), .resetn(resetn), .cfg(cfg),
    .softCaptureStrobe(softCaptureStrobe), .ffInitStrobe(ffInitStrobe), .ffInitField(ffInitField),
    .pinTimerFunction(pinTimerFunction), .extInputA(extInputA), .extInputB(extInputB),
    .gateTimerFf(gateTimerFf), .upCounter(upCounter), .captureValueA(captureValueA),
    .captureValueB(captureValueB), .outputToggleFf(outputToggleFf), .pulseOutputPin(pulseOutputPin), .irq(irq));
  tmc_ext_src tmc_ext_src_inst (.ref_clk(ref_clk), .go(go), .lineSel(lineSel), .count(cnt),
    .extInputA(extInputA), .extInputB(extInputB), .gateTimerFf(gateTimerFf), .busy(busy));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input tmc_irq_type got, input tmc_irq_type exp);
    chk({13'h0000, got}, {13'h0000, exp});
  endtask
  // pulse one pin through the model and let the edges settle
  task automatic pulses(input logic [1:0] sel, input logic [7:0] num);
    lineSel <= sel;
    cnt <= num;
    go <= 1'b1;
    @(negedge ref_clk);
    go <= 1'b0;
    for (int i = 0; i < 200 && (i < 2 || busy); i++) @(negedge ref_clk);
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic ff_init(input logic [1:0] code);
    ffInitField <= code;
    ffInitStrobe <= 1'b1;
    @(negedge ref_clk);
    ffInitStrobe <= 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // irq monitor, watchdog and main sequence
  // ----------------------------------------
  always @(negedge ref_clk)
    if (resetn && irq !== 3'h0)
    begin
      irqExp = (irqQ.size() > 0) ? irqQ.pop_front() : 3'h0;
      chk_irq(irq, irqExp);
    end
  initial
  begin
    #200000;
    bad_count++;
    complete_run();
  end
  initial
  begin
    cfg.compareValueA = 16'hff00;
    cfg.compareValueB = 16'hff00;
    repeat (8) @(negedge ref_clk);
    resetn <= 1'b1;
    cfg.run <= 1'b1;
    cfg.prescalerRun <= 1'b1;
    repeat (2) @(negedge ref_clk);
    n = 16'(3 + ($random(seed) & 7));
    pulses(2'h0, n[7:0]);
    chk(upCounter, n);
    softCaptureStrobe <= 1'b1;
    @(negedge ref_clk);
    softCaptureStrobe <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(captureValueA, n);
    chk(upCounter, n);
    cfg.prescalerRun <= 1'b0;
    pulses(2'h0, 8'h03);
    chk(upCounter, n);
    cfg.prescalerRun <= 1'b1;
    $display("test event count done");
    cfg.captureTriggerSelect <= CAP_A_RISE_FALL;
    pulses(2'h0, 8'h01);
    chk(captureValueA, n);
    chk(captureValueB, n + 16'h0001);
    cfg.captureTriggerSelect <= CAP_A_RISE;
    pulses(2'h0, 8'h01);
    pulses(2'h1, 8'h01);
    chk(captureValueA, n + 16'h0001);
    chk(captureValueB, n + 16'h0002);
    ff_init(FF_CLEAR);
    cfg.captureTriggerSelect <= CAP_GATE;
    cfg.toggleOnCaptureA <= 1'b1;
    pulses(2'h2, 8'h01);
    chk(captureValueB, n + 16'h0002);
    chk({15'h0000, outputToggleFf}, 16'h0001);
    chk({15'h0000, pulseOutputPin}, 16'h0000);
    cfg.toggleOnCaptureA <= 1'b0;
    cfg.captureTriggerSelect <= CAP_OFF;
    pinTimerFunction <= 1'b1;
    $display("test capture done");
    for (int k = 0; k < 4; k++)
    begin
      ff_init(k == 0 ? FF_SET : k == 1 ? FF_CLEAR : FF_INVERT);
      chk({15'h0000, outputToggleFf}, {15'h0000, k[0] == 1'b0});
      chk({15'h0000, pulseOutputPin}, {15'h0000, k[0] == 1'b0});
    end
    $display("test flip-flop init done");
    cfg.run <= 1'b0;
    cmpA = 16'(2 + ($random(seed) & 3));
    cmpB = cmpA + 16'(1 + ($random(seed) & 3));
    cfg.compareValueA <= cmpA;
    cfg.compareValueB <= cmpB;
    cfg.clearOnMatchEnable <= 1'b1;
    cfg.toggleOnMatchA <= 1'b1;
    cfg.toggleOnMatchB <= 1'b1;
    ff_init(FF_CLEAR);
    cfg.run <= 1'b1;
    irqQ.push_back(3'h4);
    irqQ.push_back(3'h2);
    pulses(2'h0, 8'(cmpA + 16'h0001));
    chk({15'h0000, pulseOutputPin}, 16'h0001);
    chk(upCounter, cmpA + 16'h0001);
    pulses(2'h0, 8'(cmpB - cmpA));
    chk({15'h0000, outputToggleFf}, 16'h0000);
    chk(upCounter, 16'h0000);
    chk(16'(irqQ.size()), 16'h0000);
    $display("test pulse generation done");
    cfg.run <= 1'b0;
    cfg.compareValueA <= 16'hff00;
    cfg.compareValueB <= 16'hff00;
    cfg.clockSelect <= 2'h1;
    cfg.clearOnMatchEnable <= 1'b0;
    cfg.toggleOnMatchA <= 1'b0;
    cfg.toggleOnMatchB <= 1'b0;
    cfg.captureTriggerSelect <= CAP_A_RISE;
    ff_init(FF_CLEAR);
    cfg.run <= 1'b1;
    pulses(2'h0, 8'h01);
    cmpA = captureValueA + 16'(40 + ($random(seed) & 15));
    cmpB = cmpA + 16'(2 + ($random(seed) & 3));
    irqQ.push_back(3'h4);
    irqQ.push_back(3'h2);
    cfg.compareValueA <= cmpA;
    cfg.compareValueB <= cmpB;
    cfg.toggleOnMatchA <= 1'b1;
    cfg.toggleOnMatchB <= 1'b1;
    hi = 0;
    for (int i = 0; i < 400 && upCounter !== cmpB + 16'h0001; i++)
    begin
      @(negedge ref_clk);
      hi = hi + int'(pulseOutputPin);
    end
    cfg.toggleOnMatchA <= 1'b0;
    cfg.toggleOnMatchB <= 1'b0;
    chk(upCounter, cmpB + 16'h0001);
    chk(16'(hi), 16'((cmpB - cmpA) * 2));
    repeat (4) @(negedge ref_clk);
    chk({15'h0000, outputToggleFf}, 16'h0000);
    chk(16'(irqQ.size()), 16'h0000);
    $display("test one-shot done");
    complete_run();
  end
endmodule
